// *** core/transceiver_main_config_regs.sv ***
// Overview of operation
// - Bits 7-5 of byte 0 pick sleep, standby (reset), synth-only, receive or transmit.
// - Bytes fall in groups main 0-12, irq 13-15, rx 16-21, pattern 22-25, tx 26, xtal 27, packet 28-31.
// - Data mode MSB is byte 1 bit 2, LSB byte 1 bit 5; 00 continuous, 01 buffered, 1x packet.
// - Byte 5 bits 7:6 size the buffer at 16, 32, 48 or 64 bytes, 16 at reset.
// - Byte 0 bit 0 selects divider set one (0, reset) or two (1).
// - Byte 1 bits 7-6 give on-off keying at 01 and frequency-shift keying at 10 (reset).
// - Byte 1 bits 4-3 give fixed, peak (reset) or average threshold; 11 is reserved.
// - Byte 0 bits 4-3 give lower, upper (reset) or alternate band.
// - Byte 0 bits 2-1 give an oscillator trim of 0 to 3 steps, 0 at reset.
`timescale 1ns/100ps
module transceiver_main_config_regs (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [6:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [6:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Buffer fill level from the data path
    input  wire logic [6:0]  buffer_level_i,
    // Decoded configuration
    output main_cfg_pkg::op_mode_t   op_mode_o,
    output logic [1:0]               band_o,
    output logic [1:0]               oscillator_trim_o,
    output logic                     divider_set_select_o,
    output logic                     modulation_onoff_o,
    output logic                     modulation_fsk_o,
    output main_cfg_pkg::data_mode_t data_mode_o,
    output logic [1:0]               onoff_threshold_kind_o,
    output logic [1:0]               if_gain_o,
    output logic [7:0]               onoff_floor_o,
    output logic [6:0]               buffer_depth_bytes_o,
    output logic [5:0]               buffer_threshold_o,
    output logic                     buffer_threshold_hit_o,
    output logic                     bit_tick_o,
    output logic                     deviation_tick_o
);
    import main_cfg_pkg::*;

    localparam int NREG = 6;

    logic [7:0] regs_r [NREG];
    logic       aw_held_r;
    logic       w_held_r;
    logic [4:0] aw_idx_r;
    logic [7:0] w_byte_r;
    logic       w_lane_r;
    logic       wr_fire;
    logic [4:0] ar_idx;

    // Byte index of a word address
    assign ar_idx = s_axi_araddr[6:2];

    // Address and data accepted in either order, each held until both are in
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
    assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aw_held_r <= 1'b0;
            aw_idx_r  <= 5'h0_0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_idx_r  <= s_axi_awaddr[6:2];
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            w_held_r <= 1'b0;
            w_byte_r <= 8'h00;
            w_lane_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_byte_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    // Register writes; the reserved top bit of byte 3 is stored like any other
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            regs_r[0] <= RST_MODE_BAND_TRIM_SELECT;
            regs_r[1] <= RST_MODULATION_DATAMODE_GAIN;
            regs_r[2] <= RST_DEVIATION_DIVISOR;
            regs_r[3] <= RST_BIT_RATE_DIVISOR;
            regs_r[4] <= RST_ONOFF_FLOOR_THRESHOLD;
            regs_r[5] <= RST_BUFFER_DEPTH_THRESHOLD;
        end else if (wr_fire && w_lane_r && aw_idx_r < 5'(NREG)) begin
            regs_r[aw_idx_r[2:0]] <= w_byte_r;
        end
    end

    // Write response: bytes 0-31 answer OKAY, beyond is an error
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_idx_r <= GRP_PACKET_LAST) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read path; bytes of the other groups live elsewhere and read as zero here
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= 32'h0000_0000;
            if (ar_idx < 5'(NREG)) begin
                s_axi_rdata[7:0] <= regs_r[ar_idx[2:0]];
            end
            s_axi_rresp  <= (ar_idx <= GRP_PACKET_LAST) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Field decode, registered so the outputs are glitch free
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            op_mode_o <= OP_STANDBY;
        end else begin
            unique case (regs_r[0][MODE_LSB +: 3])
                3'b000:  op_mode_o <= OP_SLEEP;
                3'b001:  op_mode_o <= OP_STANDBY;
                3'b010:  op_mode_o <= OP_SYNTH_ONLY;
                3'b011:  op_mode_o <= OP_RECEIVE;
                3'b100:  op_mode_o <= OP_TRANSMIT;
                default: op_mode_o <= OP_UNDEFINED;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            data_mode_o <= DM_CONTINUOUS;
        end else if (regs_r[1][DMODE_MSB_BIT]) begin
            data_mode_o <= DM_PACKET;
        end else if (regs_r[1][DMODE_LSB_BIT]) begin
            data_mode_o <= DM_BUFFERED;
        end else begin
            data_mode_o <= DM_CONTINUOUS;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            band_o                 <= RST_MODE_BAND_TRIM_SELECT[BAND_LSB +: 2];
            oscillator_trim_o      <= RST_MODE_BAND_TRIM_SELECT[TRIM_LSB +: 2];
            divider_set_select_o   <= RST_MODE_BAND_TRIM_SELECT[DIVSEL_BIT];
            modulation_onoff_o     <= 1'b0;
            modulation_fsk_o       <= 1'b1;
            onoff_threshold_kind_o <= RST_MODULATION_DATAMODE_GAIN[ONOFF_LSB +: 2];
            if_gain_o              <= RST_MODULATION_DATAMODE_GAIN[1:0];
            onoff_floor_o          <= RST_ONOFF_FLOOR_THRESHOLD;
            buffer_threshold_o     <= RST_BUFFER_DEPTH_THRESHOLD[5:0];
        end else begin
            band_o                 <= regs_r[0][BAND_LSB +: 2];
            oscillator_trim_o      <= regs_r[0][TRIM_LSB +: 2];
            divider_set_select_o   <= regs_r[0][DIVSEL_BIT];
            modulation_onoff_o     <= (regs_r[1][MODUL_LSB +: 2] == 2'b01);
            modulation_fsk_o       <= (regs_r[1][MODUL_LSB +: 2] == 2'b10);
            onoff_threshold_kind_o <= regs_r[1][ONOFF_LSB +: 2];
            if_gain_o              <= regs_r[1][1:0];
            onoff_floor_o          <= regs_r[4];
            buffer_threshold_o     <= regs_r[5][5:0];
        end
    end

    // Reserved threshold code is passed on as written; software must avoid it

    rate_divider #(.WIDTH(7), .PRESCALE(BIT_RATE_PRESCALE)) u_bit_rate (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .div_i   (regs_r[3][6:0]),
        .tick_o  (bit_tick_o)
    );

    rate_divider #(.WIDTH(8), .PRESCALE(DEVIATION_PRESCALE)) u_deviation (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .div_i   (regs_r[2]),
        .tick_o  (deviation_tick_o)
    );

    buffer_level_compare u_level (
        .clock_i       (clock_i),
        .rst_b_i       (rst_b_i),
        .depth_code_i  (regs_r[5][DEPTH_LSB +: 2]),
        .threshold_i   (regs_r[5][5:0]),
        .level_i       (buffer_level_i),
        .depth_bytes_o (buffer_depth_bytes_o),
        .above_o       (buffer_threshold_hit_o)
    );

    // Checks
    a_mode_decode: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        regs_r[0][7:5] == 3'b100 |=> op_mode_o == OP_TRANSMIT)
        else $error("mode decode wrong");

    a_data_mode: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        regs_r[1][2] |=> data_mode_o == DM_PACKET)
        else $error("packet mode not decoded");

    a_depth_size: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        regs_r[5][7:6] == 2'b11 ##1 regs_r[5][7:6] == 2'b11 |=> buffer_depth_bytes_o == 7'd64)
        else $error("buffer depth wrong");

    a_thresh_hit: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        buffer_level_i > {1'b0, regs_r[5][5:0]} |=> buffer_threshold_hit_o)
        else $error("threshold event missing");

    a_divsel_out: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $changed(regs_r[0][0]) |=> divider_set_select_o == $past(regs_r[0][0]))
        else $error("divider set select lag");

    a_onoff_decode: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        regs_r[1][7:6] == 2'b01 |=> modulation_onoff_o && !modulation_fsk_o)
        else $error("on-off keying not decoded");

    a_band_follow: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $stable(regs_r[0]) |-> band_o == regs_r[0][4:3])
        else $error("band not following");

    a_trim_follow: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $stable(regs_r[0]) |-> oscillator_trim_o == regs_r[0][2:1])
        else $error("trim not following");

    a_write_back: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        wr_fire && w_lane_r && aw_idx_r == 5'h02 |=> regs_r[2] == $past(w_byte_r))
        else $error("write not stored");

    // Bytes of the other groups answer OKAY with zero data
    a_unmapped_read: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_axi_arvalid && s_axi_arready && ar_idx >= 5'(NREG)
            |=> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == RESP_OKAY)
        else $error("unmapped read not zero");

endmodule

// *** core/main_cfg_pkg.sv ***
package main_cfg_pkg;

    // Byte addresses of the main parameter bytes
    localparam logic [4:0] ADDR_MODE_BAND_TRIM_SELECT    = 5'h00;
    localparam logic [4:0] ADDR_MODULATION_DATAMODE_GAIN = 5'h01;
    localparam logic [4:0] ADDR_DEVIATION_DIVISOR        = 5'h02;
    localparam logic [4:0] ADDR_BIT_RATE_DIVISOR         = 5'h03;
    localparam logic [4:0] ADDR_ONOFF_FLOOR_THRESHOLD    = 5'h04;
    localparam logic [4:0] ADDR_BUFFER_DEPTH_THRESHOLD   = 5'h05;

    // Parameter group bounds, by byte index
    localparam logic [4:0] GRP_MAIN_LAST     = 5'd12;
    localparam logic [4:0] GRP_IRQ_LAST      = 5'd15;
    localparam logic [4:0] GRP_RX_LAST       = 5'd21;
    localparam logic [4:0] GRP_PATTERN_LAST  = 5'd25;
    localparam logic [4:0] GRP_TX_LAST       = 5'd26;
    localparam logic [4:0] GRP_CRYSTAL_LAST  = 5'd27;
    localparam logic [4:0] GRP_PACKET_LAST   = 5'd31;

    // Reset values
    localparam logic [7:0] RST_MODE_BAND_TRIM_SELECT    = 8'h28;
    localparam logic [7:0] RST_MODULATION_DATAMODE_GAIN = 8'h88;
    localparam logic [7:0] RST_DEVIATION_DIVISOR        = 8'h03;
    localparam logic [7:0] RST_BIT_RATE_DIVISOR         = 8'h07;
    localparam logic [7:0] RST_ONOFF_FLOOR_THRESHOLD    = 8'h0c;
    localparam logic [7:0] RST_BUFFER_DEPTH_THRESHOLD   = 8'h0f;

    // Field positions
    localparam int MODE_LSB      = 5;
    localparam int BAND_LSB      = 3;
    localparam int TRIM_LSB      = 1;
    localparam int DIVSEL_BIT    = 0;
    localparam int MODUL_LSB     = 6;
    localparam int DMODE_LSB_BIT = 5;
    localparam int ONOFF_LSB     = 3;
    localparam int DMODE_MSB_BIT = 2;
    localparam int DEPTH_LSB     = 6;

    // Prescalers of the crystal for bit rate and deviation; buffer size step in bytes
    localparam int BIT_RATE_PRESCALE  = 64;
    localparam int DEVIATION_PRESCALE = 32;
    localparam int DEPTH_STEP_BYTES   = 16;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        OP_SLEEP       = 3'b000,
        OP_STANDBY     = 3'b001,
        OP_SYNTH_ONLY  = 3'b010,
        OP_RECEIVE     = 3'b011,
        OP_TRANSMIT    = 3'b100,
        OP_UNDEFINED   = 3'b111
    } op_mode_t;

    typedef enum logic [1:0] {
        DM_CONTINUOUS = 2'b00,
        DM_BUFFERED   = 2'b01,
        DM_PACKET     = 2'b10
    } data_mode_t;

endpackage

// *** core/rate_divider.sv ***
`timescale 1ns/100ps
// One-cycle tick every PRESCALE*(div+1) clocks
module rate_divider #(
    parameter int WIDTH    = 8,
    parameter int PRESCALE = 64
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_b_i,
    // Control
    input  wire logic [WIDTH-1:0] div_i,
    // Tick
    output logic                  tick_o
);
    localparam int PW = $clog2(PRESCALE);
    logic [PW-1:0]    pre_r;
    logic [WIDTH-1:0] cnt_r;
    logic             pre_end;

    // Wrap compare assumes a power of two prescale
    if (PRESCALE < 2 || (PRESCALE & (PRESCALE - 1)) != 0) begin : g_bad_prescale
        $error("rate_divider: PRESCALE must be a power of two");
    end

    assign pre_end = (pre_r == PW'(PRESCALE - 1));

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_end ? '0 : pre_r + PW'(1);
        end
    end

    // Divisor changes apply at the next prescale end; a count at or above the new divisor ticks at once
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r  <= '0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (pre_end) begin
                if (cnt_r >= div_i) begin
                    cnt_r  <= '0;
                    tick_o <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + WIDTH'(1);
                end
            end
        end
    end

endmodule

// *** core/buffer_level_compare.sv ***
`timescale 1ns/100ps
// Buffer size decode and threshold crossing
module buffer_level_compare (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_b_i,
    // Settings
    input  wire logic [1:0] depth_code_i,
    input  wire logic [5:0] threshold_i,
    input  wire logic [6:0] level_i,
    // Results
    output logic [6:0]      depth_bytes_o,
    output logic            above_o
);
    import main_cfg_pkg::*;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            depth_bytes_o <= 7'(DEPTH_STEP_BYTES);
            above_o       <= 1'b0;
        end else begin
            depth_bytes_o <= 7'(DEPTH_STEP_BYTES * (int'(depth_code_i) + 1));
            above_o       <= (level_i > {1'b0, threshold_i});
        end
    end

endmodule

// *** tb/host_axi_master.sv ***
`timescale 1ns/100ps
module host_axi_master (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    // Write channels
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [6:0]       s_axi_awaddr,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    // Read channels
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    output logic [6:0]       s_axi_araddr,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 7'h00;
        s_axi_araddr = 7'h00;
        s_axi_wdata  = 32'h0000_0000;
        s_axi_wstrb  = 4'h0;
    end

    // Released payload is inverted so a stale value is never mistaken for a live one
    task automatic write_word(input logic [6:0] addr, input logic [31:0] data,
                              input logic [3:0] strb);
        logic aw_pend;
        logic w_pend;
        logic aw_ok;
        logic w_ok;
        logic b_ok;
        @(posedge clock_i);
        aw_pend = 1'b1;
        w_pend  = 1'b1;
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= addr;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= data;
        s_axi_wstrb   <= strb;
        s_axi_bready  <= 1'b1;
        // Handshake levels taken mid-cycle, so they are the values the next edge sees
        forever begin
            @(negedge clock_i);
            aw_ok = s_axi_awready;
            w_ok  = s_axi_wready;
            b_ok  = s_axi_bvalid;
            @(posedge clock_i);
            if (aw_pend && aw_ok) begin
                aw_pend = 1'b0;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~addr;
            end
            if (w_pend && w_ok) begin
                w_pend = 1'b0;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~data;
            end
            if (b_ok) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic read_word(input logic [6:0] addr);
        logic ar_pend;
        logic ar_ok;
        logic r_ok;
        @(posedge clock_i);
        ar_pend = 1'b1;
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= addr;
        s_axi_rready  <= 1'b1;
        forever begin
            @(negedge clock_i);
            ar_ok = s_axi_arready;
            r_ok  = s_axi_rvalid;
            @(posedge clock_i);
            if (ar_pend && ar_ok) begin
                ar_pend = 1'b0;
                s_axi_arvalid <= 1'b0;
                s_axi_araddr  <= ~addr;
            end
            if (r_ok) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule

// *** tb/test_transceiver_main_config_regs.sv ***
`timescale 1ns/100ps
module test_transceiver_main_config_regs;
    import main_cfg_pkg::*;
    logic clock_i, rst_b_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, modulation_onoff_o, modulation_fsk_o, divider_set_select_o;
    logic buffer_threshold_hit_o, bit_tick_o, deviation_tick_o;
    logic [6:0]  s_axi_awaddr, s_axi_araddr, buffer_level_i, buffer_depth_bytes_o;
    logic [31:0] s_axi_wdata, s_axi_rdata, r;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, band_o, oscillator_trim_o, onoff_threshold_kind_o;
    logic [1:0]  if_gain_o;
    logic [7:0]  onoff_floor_o, v;
    logic [5:0]  buffer_threshold_o;
    op_mode_t    op_mode_o;
    data_mode_t  data_mode_o;
    logic [33:0] exp_r[$];
    logic [1:0]  exp_b[$];
    logic [31:0] seed = 32'h0000_da39;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    // Ceiling well above the longest tick intervals plus all bus traffic
    localparam int LIMIT = 20000;

    transceiver_main_config_regs i_transceiver_main_config_regs (.*);
    host_axi_master i_host_axi_master (.*);

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("counts: %0d compared, %0d mismatched", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input int idx, input logic [7:0] d);
        exp_b.push_back(RESP_OKAY);
        i_host_axi_master.write_word(7'(idx * 4), {24'h00_0000, d}, 4'hf);
    endtask

    task automatic rd(input int idx, input logic [7:0] d);
        exp_r.push_back({RESP_OKAY, 24'h00_0000, d});
        i_host_axi_master.read_word(7'(idx * 4));
    endtask

    task automatic settle();
        repeat (3) @(posedge clock_i);
    endtask

    task automatic measure(input bit dev, input int exp);
        int n;
        n = 0;
        while ((dev ? deviation_tick_o : bit_tick_o) !== 1'b1) @(negedge clock_i);
        @(negedge clock_i);
        n = 1;
        while ((dev ? deviation_tick_o : bit_tick_o) !== 1'b1) begin
            @(negedge clock_i);
            n++;
        end
        check(n, exp);
    endtask

    // Results are judged mid-cycle, before the edge that takes them
    always @(negedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            complete_run();
        end
        if (rst_b_i && s_axi_rvalid && s_axi_rready) begin
            if (exp_r.size() == 0) check(s_axi_rdata, 32'hdead_beef);
            else begin
                check(s_axi_rdata, exp_r[0][31:0]);
                check(s_axi_rresp, exp_r[0][33:32]);
                void'(exp_r.pop_front());
            end
        end
        if (rst_b_i && s_axi_bvalid && s_axi_bready) begin
            if (exp_b.size() == 0) check(s_axi_bresp, 32'hdead_beef);
            else check(s_axi_bresp, exp_b.pop_front());
        end
    end

    initial begin
        rst_b_i = 1'b0;
        buffer_level_i = 7'h00;
        repeat (20) @(posedge clock_i);
        rst_b_i <= 1'b1;
        settle();
        check(op_mode_o, OP_STANDBY);
        check(band_o, 2'b01);
        check(oscillator_trim_o, 2'b00);
        check(divider_set_select_o, 1'b0);
        check({modulation_onoff_o, modulation_fsk_o}, 2'b01);
        check(data_mode_o, DM_CONTINUOUS);
        check(onoff_threshold_kind_o, 2'b01);
        check(buffer_depth_bytes_o, 7'h10);
        check(buffer_threshold_o, 6'h0f);
        rd(0, RST_MODE_BAND_TRIM_SELECT);
        rd(1, RST_MODULATION_DATAMODE_GAIN);
        rd(2, RST_DEVIATION_DIVISOR);
        rd(3, RST_BIT_RATE_DIVISOR);
        rd(4, RST_ONOFF_FLOOR_THRESHOLD);
        rd(5, RST_BUFFER_DEPTH_THRESHOLD);
        measure(1'b0, 512);
        measure(1'b1, 128);
        $display("test reset_values done");
        for (int m = 0; m < 6; m++) begin
            r = rnd();
            v = {m[2:0], 2'(m % 3), r[1:0], r[2]};
            wr(0, v);
            settle();
            check(op_mode_o, (m < 5) ? m : int'(OP_UNDEFINED));
            check(band_o, m % 3);
            check(oscillator_trim_o, r[1:0]);
            check(divider_set_select_o, r[2]);
            rd(0, v);
        end
        $display("test mode_band_trim done");
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            v = {(i[0] ? 2'b01 : 2'b10), i[0], 2'(i % 3), i[1], r[1:0]};
            wr(1, v);
            settle();
            check({modulation_onoff_o, modulation_fsk_o}, {i[0], ~i[0]});
            check(data_mode_o, i[1] ? 2'b10 : {1'b0, i[0]});
            check(onoff_threshold_kind_o, i % 3);
            check(if_gain_o, r[1:0]);
            rd(1, v);
        end
        $display("test modulation_datamode done");
        wr(3, 8'h80);
        rd(3, 8'h80);
        measure(1'b0, 64);
        wr(3, 8'h02);
        measure(1'b0, 192);
        wr(2, 8'h00);
        measure(1'b1, 32);
        wr(2, 8'h01);
        measure(1'b1, 64);
        rd(2, 8'h01);
        $display("test tick_rates done");
        for (int d = 0; d < 4; d++) begin
            r = rnd();
            wr(5, {d[1:0], r[5:0]});
            settle();
            check(buffer_depth_bytes_o, 16 * (d + 1));
            check(buffer_threshold_o, r[5:0]);
            buffer_level_i <= {1'b0, r[5:0]};
            settle();
            check(buffer_threshold_hit_o, 1'b0);
            buffer_level_i <= {1'b0, r[5:0]} + 7'h01;
            settle();
            check(buffer_threshold_hit_o, 1'b1);
            rd(5, {d[1:0], r[5:0]});
        end
        r = rnd();
        wr(4, r[7:0]);
        settle();
        check(onoff_floor_o, r[7:0]);
        exp_b.push_back(RESP_OKAY);
        i_host_axi_master.write_word(7'h10, 32'h0000_0055, 4'h0);
        rd(4, r[7:0]);
        $display("test buffer_floor done");
        for (int k = 6; k < 32; k++) begin
            wr(k, 8'hff);
            rd(k, 8'h00);
        end
        rd(4, r[7:0]);
        $display("test group_map done");
        @(posedge clock_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd(0, RST_MODE_BAND_TRIM_SELECT);
        rd(5, RST_BUFFER_DEPTH_THRESHOLD);
        $display("test second_reset done");
        repeat (2) @(posedge clock_i);
        complete_run();
    end
endmodule
